// file: design/vfp_seq_pkg.sv
// shared constants and types for the vector fp exception sequencer
package vfp_seq_pkg;
  localparam int unsigned LANES      = 4;
  localparam int unsigned NUM_VREGS  = 8;
  localparam int unsigned VREG_W     = 128;
  localparam int unsigned VREG_IDX_W = 3;
  // control/status field positions
  localparam int unsigned FLAG_LSB   = 0;
  localparam int unsigned DENORM_ZERO_BIT = 6;
  localparam int unsigned MASK_LSB   = 7;
  localparam int unsigned RC_LSB     = 13;
  localparam int unsigned FTZ_BIT    = 15;
  // exception indices inside a six-bit group
  localparam int unsigned EXC_IE = 0;
  localparam int unsigned EXC_DE = 1;
  localparam int unsigned EXC_ZE = 2;
  localparam int unsigned EXC_OE = 3;
  localparam int unsigned EXC_UE = 4;
  localparam int unsigned EXC_PE = 5;
  localparam logic [5:0]  PRE_GROUP  = 6'h07;
  localparam logic [5:0]  POST_GROUP = 6'h38;
  localparam logic [31:0] CSR_RESET      = 32'h0000_1f80;
  localparam logic [31:0] MASK_WITH_DENORM     = 32'h0000_ffff;
  localparam logic [31:0] MASK_NO_DENORM       = 32'h0000_ffbf;
  localparam logic [31:0] MASK_IMAGE_NO_DENORM = 32'h0000_0000;
  // control register bit positions
  localparam int unsigned CR4_STATE_SAVE_BIT = 9;
  localparam int unsigned CR4_FAULT_EN_BIT   = 10;
  localparam int unsigned CR0_NATIVE_ERR_BIT = 5;
  // feature query leaf and bits
  localparam logic [31:0] FEATURE_LEAF       = 32'h0000_0001;
  localparam int unsigned FEAT_STATE_SAVE    = 24;
  localparam int unsigned FEAT_VEC_L1        = 25;
  localparam int unsigned FEAT_VEC_L2        = 26;
  localparam logic [VREG_W-1:0] VREG_RESET   = '0;

  typedef struct packed {
    logic       start;
    logic       implemented;
    logic [5:0] lane_flags_0;
    logic [5:0] lane_flags_1;
    logic [5:0] lane_flags_2;
    logic [5:0] lane_flags_3;
    logic [VREG_IDX_W-1:0] dest;
    logic [VREG_W-1:0]     result;
  } op_req_t;

  typedef struct packed {
    logic vector_fp_fault;
    logic undefined_opcode_fault;
    logic general_protection_fault;
  } fault_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_PRE_WAIT, ST_POST, ST_POST_WAIT, ST_DONE
  } seq_state_t;
endpackage

// file: design/simd_fp_exception_sequencer.sv
// exception sequencer and control state for the packed/scalar fp unit
`timescale 1ns/1ps
`default_nettype none
module simd_fp_exception_sequencer #(
  parameter bit DENORM_ZERO_SUPPORTED = 1'b1
) (
  input  wire logic                         clk_sys_in,
  input  wire logic                         rstn_in,
  input  wire logic                         soft_init_in,
  input  wire vfp_seq_pkg::op_req_t         op_req_in,
  input  wire logic                         handler_return_in,
  input  wire logic [31:0]                  cr0_in,
  input  wire logic [31:0]                  cr4_in,
  input  wire logic                         ignore_numeric_error_pin_in,
  input  wire logic [1:0]                   x87_rounding_in,
  input  wire logic                         csr_wr_in,
  input  wire logic [31:0]                  csr_wdata_in,
  input  wire logic                         query_in,
  input  wire logic [31:0]                  query_leaf_in,
  input  wire logic [vfp_seq_pkg::VREG_IDX_W-1:0] vreg_rd_idx_in,
  output logic                              busy_out,
  output logic                              done_out,
  output vfp_seq_pkg::fault_t               fault_out,
  output logic                              fp_error_out_pin_out,
  output logic [31:0]                       csr_out,
  output logic [1:0]                        rounding_out,
  output logic [31:0]                       query_edx_out,
  output logic [31:0]                       control_valid_mask_out,
  output logic [vfp_seq_pkg::VREG_W-1:0]    vreg_rd_data_out
);

  // ==========================================================
  // helpers
  function automatic logic [5:0] lane_or(input vfp_seq_pkg::op_req_t r);
    lane_or = r.lane_flags_0 | r.lane_flags_1 | r.lane_flags_2 | r.lane_flags_3;
  endfunction

  function automatic logic [31:0] valid_mask();
    valid_mask = DENORM_ZERO_SUPPORTED ? vfp_seq_pkg::MASK_WITH_DENORM
                                       : vfp_seq_pkg::MASK_NO_DENORM;
  endfunction

  // control/status writes are only taken while idle
  function automatic logic idle_write(input logic                    wr,
                                      input vfp_seq_pkg::seq_state_t st);
    idle_write = wr && (st == vfp_seq_pkg::ST_IDLE);
  endfunction

  // ==========================================================
  // state
  vfp_seq_pkg::seq_state_t state_ff;
  vfp_seq_pkg::seq_state_t nxt_state;
  vfp_seq_pkg::op_req_t    op_ff;
  logic [31:0]             csr_ff;
  logic [vfp_seq_pkg::VREG_W-1:0] vreg_ff [vfp_seq_pkg::NUM_VREGS];
  vfp_seq_pkg::fault_t     fault_ff;
  logic                    done_ff;
  logic [31:0]             edx_ff;
  logic                    soft_init_meta_ff;
  logic                    soft_init_sync_ff;

  logic [5:0] masks;
  logic [5:0] all_flags;
  logic [5:0] pre_flags;
  logic [5:0] post_flags;
  logic       pre_unmasked;
  logic       post_unmasked;
  logic       fault_en;
  logic       csr_bad;

  assign masks         = csr_ff[vfp_seq_pkg::MASK_LSB +: 6];
  assign all_flags     = lane_or(op_ff);
  assign pre_flags     = all_flags & vfp_seq_pkg::PRE_GROUP;
  assign post_flags    = all_flags & vfp_seq_pkg::POST_GROUP;
  // only fresh occurrences fault, never already-set flags
  assign pre_unmasked  = |(pre_flags & ~masks);
  assign post_unmasked = |(post_flags & ~masks);
  assign fault_en      = cr4_in[vfp_seq_pkg::CR4_FAULT_EN_BIT];
  assign csr_bad       = |(csr_wdata_in & ~valid_mask());

  // ==========================================================
  // soft init pin synchroniser
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      soft_init_meta_ff <= 1'b0;
      soft_init_sync_ff <= 1'b0;
    end else begin
      soft_init_meta_ff <= soft_init_in;
      soft_init_sync_ff <= soft_init_meta_ff;
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      vfp_seq_pkg::ST_IDLE: begin
        if (op_req_in.start && op_req_in.implemented) begin
          nxt_state = vfp_seq_pkg::ST_PRE;
        end
      end
      vfp_seq_pkg::ST_PRE: begin
        if (pre_unmasked) begin
          nxt_state = vfp_seq_pkg::ST_PRE_WAIT;
        end else begin
          nxt_state = vfp_seq_pkg::ST_POST;
        end
      end
      vfp_seq_pkg::ST_PRE_WAIT: begin
        if (handler_return_in) begin
          nxt_state = vfp_seq_pkg::ST_POST;
        end
      end
      vfp_seq_pkg::ST_POST: begin
        if (post_unmasked) begin
          nxt_state = vfp_seq_pkg::ST_POST_WAIT;
        end else begin
          nxt_state = vfp_seq_pkg::ST_DONE;
        end
      end
      vfp_seq_pkg::ST_POST_WAIT: begin
        if (handler_return_in) begin
          nxt_state = vfp_seq_pkg::ST_DONE;
        end
      end
      vfp_seq_pkg::ST_DONE: nxt_state = vfp_seq_pkg::ST_IDLE;
      default: nxt_state = vfp_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= vfp_seq_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_ff <= '0;
    end else if (state_ff == vfp_seq_pkg::ST_IDLE && op_req_in.start) begin
      op_ff <= op_req_in;
    end
  end

  // ==========================================================
  // faults; the error pin and ignore pin play no part
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_ff <= '0;
    end else begin
      fault_ff <= '0;
      if (state_ff == vfp_seq_pkg::ST_IDLE && op_req_in.start && !op_req_in.implemented) begin
        fault_ff.undefined_opcode_fault <= 1'b1;
      end
      if ((state_ff == vfp_seq_pkg::ST_PRE && pre_unmasked) ||
          (state_ff == vfp_seq_pkg::ST_POST && post_unmasked)) begin
        fault_ff.vector_fp_fault        <= fault_en;
        fault_ff.undefined_opcode_fault <= !fault_en;
      end
      if (idle_write(csr_wr_in, state_ff) && csr_bad) begin
        fault_ff.general_protection_fault <= 1'b1;
      end
    end
  end

  assign fp_error_out_pin_out = 1'b0;

  // ==========================================================
  // control/status register; soft init does not touch it
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      csr_ff <= vfp_seq_pkg::CSR_RESET;
    end else if (!soft_init_sync_ff) begin
      if (idle_write(csr_wr_in, state_ff) && !csr_bad) begin
        csr_ff <= csr_wdata_in & valid_mask();
      end else if (state_ff == vfp_seq_pkg::ST_PRE) begin
        csr_ff[vfp_seq_pkg::FLAG_LSB +: 6] <= csr_ff[vfp_seq_pkg::FLAG_LSB +: 6] | pre_flags;
      end else if (state_ff == vfp_seq_pkg::ST_POST) begin
        csr_ff[vfp_seq_pkg::FLAG_LSB +: 6] <= csr_ff[vfp_seq_pkg::FLAG_LSB +: 6] | post_flags;
      end
    end
  end

  // ==========================================================
  // vector registers: result written only on completion
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < vfp_seq_pkg::NUM_VREGS; i++) begin
        vreg_ff[i] <= vfp_seq_pkg::VREG_RESET;
      end
    end else if (!soft_init_sync_ff && state_ff == vfp_seq_pkg::ST_DONE) begin
      vreg_ff[op_ff.dest] <= op_ff.result;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == vfp_seq_pkg::ST_DONE);
    end
  end

  // ==========================================================
  // feature query
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      edx_ff <= '0;
    end else if (query_in) begin
      edx_ff <= '0;
      if (query_leaf_in == vfp_seq_pkg::FEATURE_LEAF) begin
        edx_ff[vfp_seq_pkg::FEAT_STATE_SAVE] <= 1'b1;
        edx_ff[vfp_seq_pkg::FEAT_VEC_L1]     <= 1'b1;
        edx_ff[vfp_seq_pkg::FEAT_VEC_L2]     <= 1'b1;
      end
    end
  end

  assign busy_out  = (state_ff != vfp_seq_pkg::ST_IDLE);
  assign done_out  = done_ff;
  assign fault_out = fault_ff;
  assign csr_out   = csr_ff;
  // x87 rounding input is deliberately unused
  assign rounding_out  = csr_ff[vfp_seq_pkg::RC_LSB +: 2];
  assign query_edx_out = edx_ff;
  assign control_valid_mask_out = DENORM_ZERO_SUPPORTED ? vfp_seq_pkg::MASK_WITH_DENORM
                                                        : vfp_seq_pkg::MASK_IMAGE_NO_DENORM;
  assign vreg_rd_data_out = vreg_ff[vreg_rd_idx_in];

endmodule
`default_nettype wire

// file: verification/vfp_seq_props.sv
// assertion checker for the vector fp exception sequencer
`timescale 1ns/1ps
`default_nettype none
module vfp_seq_props #(
  parameter bit DENORM_ZERO_SUPPORTED = 1'b1
) (
  input wire logic                 clk_sys_in,
  input wire logic                 rstn_in,
  input wire logic                 soft_init_in,
  input wire vfp_seq_pkg::op_req_t op_req_in,
  input wire logic [31:0]          cr4_in,
  input wire logic                 csr_wr_in,
  input wire logic [31:0]          csr_wdata_in,
  input wire logic                 query_in,
  input wire logic [31:0]          query_leaf_in,
  input wire logic                 busy_out,
  input wire vfp_seq_pkg::fault_t  fault_out,
  input wire logic                 fp_error_out_pin_out,
  input wire logic [31:0]          csr_out,
  input wire logic [1:0]           rounding_out,
  input wire logic [31:0]          query_edx_out,
  input wire logic [31:0]          control_valid_mask_out
);
  localparam logic [31:0] VMASK = DENORM_ZERO_SUPPORTED ? 32'h0000_ffff : 32'h0000_ffbf;
  default clocking dcb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // ==========================================
  // faults, pins and control state
  err_pin_a: assert property (fp_error_out_pin_out == 1'b0) else $error("error pin set");
  vec_en_a: assert property (fault_out.vector_fp_fault |-> $past(cr4_in[10]))
    else $error("vector fault with enable clear");
  undef_op_a: assert property (op_req_in.start && !op_req_in.implemented && !busy_out
    |=> fault_out.undefined_opcode_fault) else $error("no undefined fault");
  gp_write_a: assert property (csr_wr_in && !busy_out && ((csr_wdata_in & ~VMASK) != 32'h0)
    |=> fault_out.general_protection_fault && $stable(csr_out)) else $error("no protection fault");
  csr_write_a: assert property (csr_wr_in && !busy_out && !$past(soft_init_in, 2) &&
    ((csr_wdata_in & ~VMASK) == 32'h0) |=> csr_out == $past(csr_wdata_in) &&
    !fault_out.vector_fp_fault) else $error("write not taken");
  feat_bits_a: assert property (query_in && query_leaf_in == 32'h0000_0001
    |=> query_edx_out[26:24] == 3'h7) else $error("feature bits missing");
  rnd_map_a: assert property (rounding_out == csr_out[14:13]) else $error("rounding");
  mask_image_a: assert property (control_valid_mask_out == (DENORM_ZERO_SUPPORTED ? 32'h0000_ffff
    : 32'h0)) else $error("mask image");
  init_hold_a: assert property ($past(soft_init_in) |=> $stable(csr_out)) else $error("csr moved");
  csr_reset_a: assert property ($rose(rstn_in) |-> csr_out == 32'h0000_1f80)
    else $error("csr reset value");
endmodule
bind simd_fp_exception_sequencer vfp_seq_props #(.DENORM_ZERO_SUPPORTED(DENORM_ZERO_SUPPORTED))
  u_props (
  .clk_sys_in, .rstn_in, .soft_init_in, .op_req_in, .cr4_in, .csr_wr_in, .csr_wdata_in,
  .query_in, .query_leaf_in, .busy_out, .fault_out, .fp_error_out_pin_out, .csr_out,
  .rounding_out, .query_edx_out, .control_valid_mask_out);
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the vector fp exception sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                 clk, rst_n, sinit, hret, cwr, qry, ign, busy, done, perr;
  logic [31:0]          cr0, cr4, wdata, leaf, seed, mcsr, csr, edx, vmask;
  logic [1:0]           x87r, rnd;
  logic [2:0]           ridx;
  logic [127:0]         vdata;
  logic [127:0]         mv [8];
  vfp_seq_pkg::op_req_t req;
  vfp_seq_pkg::fault_t  flt;
  int                   err_count, checks;
  simd_fp_exception_sequencer #(.DENORM_ZERO_SUPPORTED(1'b0)) u_simd_fp_exception_sequencer (
    .clk_sys_in(clk), .rstn_in(rst_n), .soft_init_in(sinit), .op_req_in(req),
    .handler_return_in(hret), .cr0_in(cr0), .cr4_in(cr4), .ignore_numeric_error_pin_in(ign),
    .x87_rounding_in(x87r), .csr_wr_in(cwr), .csr_wdata_in(wdata), .query_in(qry),
    .query_leaf_in(leaf), .vreg_rd_idx_in(ridx), .busy_out(busy), .done_out(done),
    .fault_out(flt), .fp_error_out_pin_out(perr), .csr_out(csr), .rounding_out(rnd),
    .query_edx_out(edx), .control_valid_mask_out(vmask), .vreg_rd_data_out(vdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic step;
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    cr0  = seed;
    ign  = seed[3];
    x87r = seed[5:4];
  endtask
  task automatic final_report;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rst_chk;
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    mcsr  = vfp_seq_pkg::CSR_RESET;
    for (int i = 0; i < 8; i++) begin
      mv[i] = '0;
      ridx  = 3'(i);
      #1 chk(vdata, '0);
    end
    chk(csr, mcsr);
    chk(vmask, '0);
  endtask
  task automatic wr(input logic [31:0] d);
    @(negedge clk);
    cwr   = 1'b1;
    wdata = d;
    @(negedge clk);
    cwr = 1'b0;
    if (!sinit && (d & ~vfp_seq_pkg::MASK_NO_DENORM) == 32'h0) mcsr = d;
    chk(flt, {2'b00, (d & ~vfp_seq_pkg::MASK_NO_DENORM) != 32'h0});
    chk(csr, mcsr);
    chk(rnd, mcsr[14:13]);
  endtask
  task automatic op(input bit impl, input logic [23:0] lf);
    int nv, nu, ev, eu;
    logic [5:0] o, pr, po;
    bit dn;
    o  = lf[5:0] | lf[11:6] | lf[17:12] | lf[23:18];
    pr = impl ? o & vfp_seq_pkg::PRE_GROUP & ~mcsr[12:7] : 6'h0;
    po = impl ? o & vfp_seq_pkg::POST_GROUP & ~mcsr[12:7] : 6'h0;
    ev = cr4[10] ? int'(pr != 0) + int'(po != 0) : 0;
    eu = int'(!impl) + (cr4[10] ? 0 : int'(pr != 0) + int'(po != 0));
    nv = 0;
    nu = 0;
    dn = 1'b0;
    step();
    @(negedge clk);
    req = {1'b1, impl, lf[5:0], lf[11:6], lf[17:12], lf[23:18], seed[2:0], {4{seed}}};
    ridx = seed[2:0];
    for (int i = 0; i < 40 && !dn; i++) begin
      @(negedge clk);
      req.start = 1'b0;
      hret = 1'b0;
      if (flt.vector_fp_fault === 1'b1 || flt.undefined_opcode_fault === 1'b1) begin
        if (busy === 1'b1) chk(vdata, mv[req.dest]);
        chk(perr, 1'b0);
        nv += int'(flt.vector_fp_fault);
        nu += int'(flt.undefined_opcode_fault);
        hret = (busy === 1'b1);
      end
      dn = (done === 1'b1) || (i > 3 && busy === 1'b0);
    end
    chk(nv, ev);
    chk(nu, eu);
    if (impl) mcsr[5:0] = mcsr[5:0] | o;
    chk(csr, mcsr);
    if (impl && cr4[10]) mv[req.dest] = req.result;
    if (impl && cr4[10]) chk(vdata, mv[req.dest]);
  endtask
  // ==========================================
  // main sequence
  initial begin
    {rst_n, sinit, hret, cwr, qry, wdata, leaf, ridx} = '0;
    req  = '0;
    cr4  = 32'h0000_0600;
    seed = 32'ha297;
    step();
    rst_chk();
    for (int l = 1; l < 3; l++) begin
      @(negedge clk);
      {qry, leaf} = {1'b1, 32'(l)};
      @(negedge clk);
      qry = 1'b0;
      chk(edx, l == 1 ? 32'h0700_0000 : 32'h0);
    end
    wr(32'h0000_1fc0);
    op(1'b1, {4{6'h3f}});
    wr(32'h0000_003f);
    op(1'b1, 24'h81_0421);
    for (int k = 0; k < 4; k++) begin
      wr(seed & vfp_seq_pkg::MASK_NO_DENORM);
      op(1'b1, seed[29:6]);
    end
    wr(32'h0);
    cr4 = 32'h0000_0200;
    op(1'b1, 24'h00_0007);
    op(1'b0, 24'h0);
    sinit = 1'b1;
    repeat (2) @(negedge clk);
    wr(32'h0000_1f80);
    sinit = 1'b0;
    rst_chk();
    final_report();
  end
  initial begin
    #20000;
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
